// File: include/acbc_pkg.sv
// constants, types and decoders shared by the converter control block
package acbc_pkg;
    localparam logic [1:0] ADDR_RESULT = 2'h0;
    localparam logic [1:0] ADDR_CONFIG = 2'h1;
    localparam logic [1:0] ADDR_LOWER = 2'h2;
    localparam logic [1:0] ADDR_UPPER = 2'h3;

    localparam int CFG_START = 15;
    localparam int CFG_GAIN_LO = 9;
    localparam int CFG_MODE = 8;
    localparam int CFG_STYLE = 4;
    localparam int CFG_POL = 3;
    localparam int CFG_LATCH = 2;
    localparam int CFG_QUE_LO = 0;

    localparam logic [1:0] QUE_ONE = 2'h0;
    localparam logic [1:0] QUE_TWO = 2'h1;
    localparam logic [1:0] QUE_FOUR = 2'h2;
    localparam logic [1:0] QUE_OFF = 2'h3;

    localparam logic RST_MODE = 1'h1;
    localparam logic RST_POL = 1'h0;
    localparam logic RST_STYLE = 1'h0;
    localparam logic RST_LATCH = 1'h0;
    localparam logic [2:0] RST_GAIN = 3'h2;
    localparam logic [1:0] RST_QUE = QUE_OFF;
    localparam logic [15:0] RST_UPPER = 16'h7ff0;
    localparam logic [15:0] RST_LOWER = 16'h8000;
    localparam logic [3:0] RES_PAD = 4'h0;

    // all sequencing counts oscillator ticks, never mclk cycles
    localparam int OSC_KHZ = 1000;
    localparam int PWRUP_US = 25;
    localparam int RDY_US = 8;
    localparam int CONV_US = 300;
    localparam logic [9:0] PWRUP_TICKS = 10'(PWRUP_US * OSC_KHZ / 1000);
    localparam logic [9:0] CONV_TICKS = 10'(CONV_US * OSC_KHZ / 1000);
    localparam logic [3:0] RDY_TICKS = 4'(RDY_US * OSC_KHZ / 1000);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PWRUP = 2'b01,
        ST_CONV = 2'b10
    } acbc_state_t;

    // step size in microvolts: full scale over 2048 codes
    function automatic logic [11:0] gain_lsb_uv(input logic [2:0] g);
        case (g)
            3'h0: gain_lsb_uv = 12'hbb8;
            3'h1: gain_lsb_uv = 12'h7d0;
            3'h2: gain_lsb_uv = 12'h3e8;
            3'h3: gain_lsb_uv = 12'h1f4;
            3'h4: gain_lsb_uv = 12'h0fa;
            default: gain_lsb_uv = 12'h07d;
        endcase
    endfunction
endpackage

// File: include/acbc_cmp_if.sv
// link between sequencer and threshold comparator
`timescale 1ns/100ps
interface acbc_cmp_if;
    logic eval;
    logic [15:0] result;
    logic [15:0] upper;
    logic [15:0] lower;
    logic style;
    logic latch;
    logic [1:0] que;
    logic clear;
    logic trip;
    logic high;
    modport ctrl (output eval, result, upper, lower, style, latch, que, clear,
        input trip, high);
    modport cmp (input eval, result, upper, lower, style, latch, que, clear,
        output trip, high);
endinterface

// File: verilog/acbc_osc_sync.sv
// oscillator input synchroniser and rising-edge tick
`timescale 1ns/100ps
module acbc_osc_sync
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic osc_in,
    output logic tick
);
    typedef struct packed {
        logic [2:0] sync;
        logic lvl;
    } acbc_sync_t;

    acbc_sync_t r;
    acbc_sync_t n;

    // sync[0] only feeds sync[1]; a level counts once sync[1] and sync[2] agree
    always_comb
    begin
        n = r;
        tick = 1'b0;
        n.sync = {r.sync[1:0], osc_in};
        if (r.sync[1] == r.sync[2] && r.sync[2] != r.lvl)
        begin
            n.lvl = r.sync[2];
            tick = ce & r.sync[2];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            r <= '0;
        else if (ce)
            r <= n;
    end
endmodule // acbc_osc_sync

// File: verilog/acbc_comp.sv
// threshold comparator with queue count and latch
`timescale 1ns/100ps
module acbc_comp
    import acbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    acbc_cmp_if.cmp cb
);
    typedef struct packed {
        logic [2:0] cnt;
        logic act;
        logic high;
    } acbc_cmp_t;

    acbc_cmp_t r;
    acbc_cmp_t n;
    logic above;
    logic below;
    logic beyond;
    logic [2:0] tally;
    logic [2:0] need;

    always_comb
    begin
        n = r;
        above = $signed(cb.result) > $signed(cb.upper);
        below = $signed(cb.result) < $signed(cb.lower);
        beyond = cb.style ? (above | below) : above;
        tally = (r.cnt == 3'h7) ? r.cnt : r.cnt + 3'h1;
        case (cb.que)
            QUE_ONE: need = 3'h1;
            QUE_TWO: need = 3'h2;
            QUE_FOUR: need = 3'h4;
            default: need = 3'h7;
        endcase
        if (cb.clear)
            n.act = 1'b0;
        // a fresh violation in the clearing cycle still sets
        if (cb.eval)
        begin
            if (beyond)
            begin
                n.cnt = tally;
                if (tally >= need)
                begin
                    n.act = 1'b1;
                    n.high = above;
                end
            end
            else
            begin
                n.cnt = 3'h0;
                if (!cb.latch && (cb.style || below))
                    n.act = 1'b0;
            end
        end
        if (cb.que == QUE_OFF)
            n = '0;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            r <= '0;
        else if (ce)
            r <= n;
    end

    assign cb.trip = r.act;
    assign cb.high = r.high;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    latch_hold_a: assert property (r.act && cb.latch && !cb.clear && ce // R6
        && cb.que != QUE_OFF |=> r.act) else $error("latched alert dropped");
    queue_two_a: assert property (ce && cb.eval && cb.que == QUE_TWO && r.cnt == 3'h0 // R8
        && !r.act && !cb.clear |=> !r.act) else $error("alert before two results");
    window_high_a: assert property (ce && cb.eval && cb.style && cb.que == QUE_ONE // R16
        && above |=> r.act && r.high) else $error("upper violation status wrong");
endmodule // acbc_comp

// File: verilog/acbc_ctrl.sv
// conversion sequencer, register file and alert pin control
// Functional notes
// R1: gain_range_sel picks one of six ranges, 6.144 V down to 0.256 V.
// R2: step size is full scale over 2048, 0.125 mV at smallest range.
// R3: all conversion timing counts ticks of the 1 MHz oscillator.
// R4: traditional style asserts above upper_limit, releases only below lower_limit.
// R5: window style asserts when result is above upper or below lower.
// R6: latched alert holds until result is read or alert response won.
// R7: alert_polarity sets active level; active low after reset.
// R8: alert after 1, 2 or 4 successive violations; code 11 disables.
// R9: upper top bit 1, lower top bit 0, queue not 11: ready function.
// R10: continuous mode with ready function gives 8 us pulse per conversion.
// R11: single-shot ready with polarity 0 drives pin low at conversion end.
// R12: cleared latch reasserts on later violation; clearing never disturbs conversion.
// R13: alert pin is open drain and stays released while comparator disabled.
// R14: master sends alert response address; alerting devices return their address.
// R15: lowest address wins; only winner clears; master repeats until all clear.
// R16: window style status bit is 1 for upper, 0 for lower violation.
// R17: reset loads configuration defaults then sits powered down, logic awake.
// R18: general call reset acts exactly like the power-up reset.
// R19: mode bit 1 is single-shot and default; 0 is continuous.
// R20: start write powers up in about 25 us, clears bit, converts once.
// R21: start write during a conversion is ignored.
// R22: continuous mode stores each result and starts the next at once.
// R23: general call second byte 00000110 resets registers and powers down.
// R24: comparator and queue evaluated once per result, signed, both limits.
`timescale 1ns/100ps
module acbc_ctrl
    import acbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic osc_in,
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic [11:0] adc_code,
    output logic [2:0] gain_sel,
    output logic [11:0] lsb_uv,
    output logic powered,
    output logic conv_run,
    input wire logic gcall_reset,
    input wire logic ara_req,
    input wire logic ara_won,
    output logic ara_ack,
    output logic ara_status,
    input wire logic alert_i,
    output logic alert_o,
    output logic alert_oe
);
    typedef struct packed {
        acbc_state_t st;
        logic [9:0] cnt;
        logic mode;
        logic [2:0] gain;
        logic style;
        logic pol;
        logic latch;
        logic [1:0] que;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] result;
        logic [15:0] rdata;
        logic rdy;
        logic [3:0] rdy_cnt;
    } acbc_ctrl_t;

    localparam acbc_ctrl_t CTRL_RST = '{
        st: ST_IDLE,
        cnt: '0,
        mode: RST_MODE,
        gain: RST_GAIN,
        style: RST_STYLE,
        pol: RST_POL,
        latch: RST_LATCH,
        que: RST_QUE,
        upper: RST_UPPER,
        lower: RST_LOWER,
        result: '0,
        rdata: '0,
        rdy: 1'b0,
        rdy_cnt: '0
    };

    acbc_ctrl_t r;
    acbc_ctrl_t n;
    logic tick;
    logic done;
    logic start;
    logic rdy_mode;
    logic act;
    logic busy;

    acbc_cmp_if cb ();

    function automatic logic hit(input logic strobe, input logic [1:0] a,
        input logic [1:0] target);
        hit = strobe && (a == target);
    endfunction

    acbc_osc_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .osc_in(osc_in),
        .tick(tick)
    );

    acbc_comp u_comp (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .cb(cb)
    );

    assign busy = (r.st != ST_IDLE);
    assign rdy_mode = r.upper[15] && !r.lower[15] && (r.que != QUE_OFF); // R9

    always_comb
    begin
        n = r;
        done = 1'b0;
        // a start only counts from power-down in single-shot mode
        start = hit(wr, addr, ADDR_CONFIG) && wdata[CFG_START] // R20
            && wdata[CFG_MODE] && !busy; // R21

        if (hit(wr, addr, ADDR_CONFIG))
        begin
            n.gain = wdata[CFG_GAIN_LO +: 3]; // R1
            n.mode = wdata[CFG_MODE]; // R19
            n.style = wdata[CFG_STYLE];
            n.pol = wdata[CFG_POL]; // R7
            n.latch = wdata[CFG_LATCH];
            n.que = wdata[CFG_QUE_LO +: 2]; // R8
        end
        if (hit(wr, addr, ADDR_UPPER))
            n.upper = wdata;
        if (hit(wr, addr, ADDR_LOWER))
            n.lower = wdata;

        case (r.st)
            ST_IDLE:
            begin
                if (start || !r.mode)
                begin
                    n.st = ST_PWRUP; // R20
                    n.cnt = PWRUP_TICKS - 10'h1;
                    n.rdy = 1'b0;
                end
            end
            ST_PWRUP:
            begin
                if (tick) // R3
                begin
                    if (r.cnt == 10'h0)
                    begin
                        n.st = ST_CONV;
                        n.cnt = CONV_TICKS - 10'h1;
                    end
                    else
                        n.cnt = r.cnt - 10'h1;
                end
            end
            ST_CONV:
            begin
                if (tick) // R3
                begin
                    if (r.cnt == 10'h0)
                    begin
                        done = 1'b1;
                        n.result = {adc_code, RES_PAD}; // R22
                        n.cnt = CONV_TICKS - 10'h1;
                        // single-shot drops back to power-down
                        n.st = r.mode ? ST_IDLE : ST_CONV; // R22
                    end
                    else
                        n.cnt = r.cnt - 10'h1;
                end
            end
            default:
                n.st = ST_IDLE;
        endcase

        // continuous ready is a timed pulse; single-shot holds until next start
        if (r.rdy && !r.mode && tick)
        begin
            if (r.rdy_cnt <= 4'h1)
                n.rdy = 1'b0; // R10
            else
                n.rdy_cnt = r.rdy_cnt - 4'h1;
        end
        if (done && rdy_mode)
        begin
            n.rdy = 1'b1; // R10 R11
            n.rdy_cnt = RDY_TICKS;
        end

        if (rd)
        begin
            case (addr)
                ADDR_RESULT: n.rdata = r.result;
                ADDR_CONFIG:
                begin
                    n.rdata = '0;
                    n.rdata[CFG_START] = !busy; // R20
                    n.rdata[CFG_GAIN_LO +: 3] = r.gain;
                    n.rdata[CFG_MODE] = r.mode;
                    n.rdata[CFG_STYLE] = r.style;
                    n.rdata[CFG_POL] = r.pol;
                    n.rdata[CFG_LATCH] = r.latch;
                    n.rdata[CFG_QUE_LO +: 2] = r.que;
                end
                ADDR_LOWER: n.rdata = r.lower;
                default: n.rdata = r.upper;
            endcase
        end

        if (gcall_reset)
            n = CTRL_RST; // R18 R23
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            r <= CTRL_RST; // R17
        else if (ce)
            r <= n;
    end

    // comparator sees each result once, in the cycle it is stored
    assign cb.eval = done && !gcall_reset; // R24
    assign cb.result = {adc_code, RES_PAD};
    assign cb.upper = r.upper;
    assign cb.lower = r.lower;
    assign cb.style = r.style; // R4 R5
    assign cb.latch = r.latch; // R6
    assign cb.que = r.que;
    // clearing touches only the comparator, never the sequencer
    assign cb.clear = hit(rd, addr, ADDR_RESULT) || ara_won || gcall_reset; // R6 R12 R15

    assign act = rdy_mode ? r.rdy : cb.trip; // R9
    // drive low only; disabled comparator leaves the line released
    assign alert_oe = (r.que != QUE_OFF) && (act ^ r.pol); // R7 R13
    assign alert_o = 1'b0;

    // answering is ready-mode blind: only a real comparator alert answers
    assign ara_ack = ara_req && cb.trip && !rdy_mode; // R14
    assign ara_status = cb.high; // R16

    assign rdata = r.rdata;
    assign gain_sel = r.gain; // R1
    assign lsb_uv = gain_lsb_uv(r.gain); // R2
    assign powered = busy; // R17
    assign conv_run = (r.st == ST_CONV);

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    busy_start_a: assert property (ce && busy && !gcall_reset && hit(wr, addr, ADDR_CONFIG) // R21
        |=> r.st != ST_PWRUP || $past(r.st) == ST_PWRUP) else $error("start taken while busy");
    start_pwrup_a: assert property (ce && start && !gcall_reset // R20
        |=> r.st == ST_PWRUP && r.cnt == PWRUP_TICKS - 10'h1) else $error("start missed");
    store_next_a: assert property (ce && done && !r.mode && !gcall_reset // R22
        |=> r.st == ST_CONV && r.result == {$past(adc_code), RES_PAD})
        else $error("continuous result not stored");
    release_off_a: assert property (r.que == QUE_OFF |-> !alert_oe) // R13
        else $error("pin driven while disabled");
    pol_low_a: assert property (!r.pol && r.que != QUE_OFF |-> alert_oe == act) // R7
        else $error("active low drive wrong");
    gcall_reset_a: assert property (ce && gcall_reset // R18
        |=> r.st == ST_IDLE && r.mode && r.que == RST_QUE) else $error("general call reset");
    ready_pulse_a: assert property (ce && done && rdy_mode && !r.mode && !gcall_reset // R10
        |=> r.rdy) else $error("ready pulse missing");
    single_ready_a: assert property (ce && done && rdy_mode && r.mode && !r.pol // R11
        && !gcall_reset |=> alert_oe [*2]) else $error("single ready low");
    ready_stays_a: assert property (ce && r.rdy && r.mode && r.st == ST_IDLE && !start // R11
        && !gcall_reset |=> r.rdy) else $error("single-shot ready dropped");
endmodule // acbc_ctrl

// File: testbench/acbc_host_model.sv
// behavioural bus master: general call reset and repeated alert response
`timescale 1ns/100ps
module acbc_host_model
(
    input wire logic mclk,
    input wire logic go_ara,
    input wire logic go_gcall,
    input wire logic ara_ack,
    input wire logic alert_pin,
    output logic ara_req = 1'b0,
    output logic ara_won = 1'b0,
    output logic gcall_reset = 1'b0,
    output logic [2:0] tries = 3'h0
);
    always @(posedge mclk)
    begin
        // second byte 06 of a general call already decoded here
        gcall_reset <= go_gcall;
        // pin sensed low: keep answering until it is released
        ara_req <= go_ara && !alert_pin;
        // single device on the bus, so it always has the lowest address
        ara_won <= ara_req && ara_ack && !ara_won;
        if (ara_won)
            tries <= tries + 3'h1;
    end
endmodule // acbc_host_model

// File: testbench/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module testbench;
    import acbc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_in = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [11:0] adc_code = 12'h000;
    logic go_ara = 1'b0;
    logic go_gcall = 1'b0;
    logic [15:0] rdata;
    logic [2:0] gain_sel;
    logic [11:0] lsb_uv;
    logic powered, conv_run, gcall_reset, ara_req, ara_won, ara_ack, ara_status;
    logic alert_o, alert_oe, alert_pin;
    logic [2:0] tries;
    int miscompares = 0;
    int n_compared = 0;
    always #12.5 mclk = ~mclk;
    always #100 osc_in = ~osc_in;
    // open drain with pull-up
    assign alert_pin = alert_oe ? alert_o : 1'b1;
    acbc_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .osc_in(osc_in), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .adc_code(adc_code),
        .gain_sel(gain_sel), .lsb_uv(lsb_uv), .powered(powered), .conv_run(conv_run),
        .gcall_reset(gcall_reset), .ara_req(ara_req), .ara_won(ara_won), .ara_ack(ara_ack),
        .ara_status(ara_status), .alert_i(alert_pin), .alert_o(alert_o), .alert_oe(alert_oe));
    acbc_host_model host_u (.mclk(mclk), .go_ara(go_ara), .go_gcall(go_gcall),
        .ara_ack(ara_ack), .alert_pin(alert_pin), .ara_req(ara_req), .ara_won(ara_won),
        .gcall_reset(gcall_reset), .tries(tries));

    task automatic give_verdict();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rchk(input logic [1:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask
    task automatic wait_oe(input logic v, input int lim, output int n);
        n = 0;
        while (alert_oe !== v && n < lim)
        begin
            @(posedge mclk);
            #1 n++;
        end
        chk(16'(alert_oe), 16'(v));
    endtask
    // one single-shot conversion; again re-issues start while busy
    task automatic shot(input logic [15:0] cfg, input logic [11:0] code, input logic again,
        output int n);
        realtime t0;
        logic [15:0] d;
        adc_code <= code;
        wr_reg(ADDR_CONFIG, cfg);
        t0 = $realtime;
        #1 chk(16'(powered), 16'h1);
        chk(16'(conv_run), 16'h0);
        if (again)
        begin
            repeat (300) @(posedge mclk);
            wr_reg(ADDR_CONFIG, cfg);
            rd_reg(ADDR_CONFIG, d);
            chk(16'(d[15]), 16'h0);
        end
        while (powered !== 1'b0 && $realtime - t0 < 100000.0)
            @(posedge mclk);
        n = int'(($realtime - t0) / 25.0);
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic t_reset();
        rchk(ADDR_CONFIG, 16'h8503);
        rchk(ADDR_UPPER, 16'h7ff0);
        rchk(ADDR_LOWER, 16'h8000);
        chk(16'(powered), 16'h0);
        chk(16'(alert_pin), 16'h1);
        chk(16'(alert_o), 16'h0);
    endtask
    task automatic t_gain();
        logic [11:0] tab [6] = '{12'hbb8, 12'h7d0, 12'h3e8, 12'h1f4, 12'h0fa, 12'h07d};
        for (int g = 0; g < 6; g++)
        begin
            wr_reg(ADDR_CONFIG, 16'h0103 | (16'(g) << 9));
            #1 chk(16'(lsb_uv), 16'(tab[g]));
            chk(16'(gain_sel), 16'(g));
            rchk(ADDR_CONFIG, 16'h8103 | (16'(g) << 9));
        end
    endtask
    task automatic t_window();
        int n;
        wr_reg(ADDR_UPPER, 16'h1000);
        wr_reg(ADDR_LOWER, 16'hf000);
        shot(16'h8514, 12'h200, 1'b1, n);
        chk(16'(n >= 2580 && n <= 2640), 16'h1);
        chk(16'(alert_oe), 16'h1);
        chk(16'(ara_status), 16'h1);
        shot(16'h8514, 12'h000, 1'b0, n);
        chk(16'(alert_oe), 16'h1);
        rchk(ADDR_RESULT, 16'h0000);
        repeat (2) @(posedge mclk);
        #1 chk(16'(alert_oe), 16'h0);
        shot(16'h8514, 12'he00, 1'b0, n);
        chk(16'(alert_oe), 16'h1);
        chk(16'(ara_status), 16'h0);
        go_ara <= 1'b1;
        wait_oe(1'b0, 50, n);
        go_ara <= 1'b0;
        chk(16'(tries != 3'h0), 16'h1);
    endtask
    task automatic t_trad();
        logic [11:0] code [6] = '{12'h0c0, 12'h200, 12'h200, 12'h0c0, 12'h040, 12'h040};
        logic exp [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        int n;
        wr_reg(ADDR_UPPER, 16'h1000);
        wr_reg(ADDR_LOWER, 16'h0800);
        for (int i = 0; i < 6; i++)
        begin
            shot(i < 5 ? 16'h8501 : 16'h8508, code[i], 1'b0, n);
            chk(16'(alert_oe), 16'(exp[i]));
        end
    endtask
    task automatic t_ready();
        int n;
        wr_reg(ADDR_UPPER, 16'h8000);
        wr_reg(ADDR_LOWER, 16'h0000);
        shot(16'h8500, 12'h100, 1'b0, n);
        chk(16'(alert_oe), 16'h1);
        chk(16'(alert_pin), 16'h0);
        @(posedge mclk);
        go_gcall <= 1'b1;
        @(posedge mclk);
        go_gcall <= 1'b0;
        repeat (3) @(posedge mclk);
        rchk(ADDR_CONFIG, 16'h8503);
        rchk(ADDR_UPPER, 16'h7ff0);
        chk(16'(alert_oe), 16'h0);
    endtask
    task automatic t_cont();
        int n;
        wr_reg(ADDR_UPPER, 16'h8000);
        wr_reg(ADDR_LOWER, 16'h0000);
        adc_code <= 12'h123;
        wr_reg(ADDR_CONFIG, 16'h0400);
        wait_oe(1'b1, 4000, n);
        wait_oe(1'b0, 200, n);
        chk(16'(n >= 56 && n <= 72), 16'h1);
        rchk(ADDR_RESULT, 16'h1230);
        adc_code <= 12'h456;
        wait_oe(1'b1, 4000, n);
        // no power-up between back-to-back conversions
        chk(16'(n >= 2310 && n <= 2350), 16'h1);
        rchk(ADDR_RESULT, 16'h4560);
        wr_reg(ADDR_CONFIG, 16'h0503);
    endtask

    initial
    begin
        #1500000;
        miscompares++;
        give_verdict();
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_gain();
        t_window();
        t_trad();
        t_ready();
        t_cont();
        give_verdict();
    end
endmodule // testbench
